//--- rtl/mcsd_pkg.sv
/*
 * mcsd_pkg: constants and types shared by the main clock select and
 * distribution block and its system divider.
 * assumes: included before the interface and the modules that import it.
 */
package mcsd_pkg;
	// register offsets in the i/o space
	localparam logic [5:0] OFS_DIVIDER = 6'h36;
	localparam logic [5:0] OFS_SOURCE = 6'h37;
	localparam logic [5:0] OFS_TRIM = 6'h39;
	localparam logic [5:0] OFS_PROTECT = 6'h3c;
	// main source select codes
	localparam logic [1:0] SRC_INT8 = 2'h0;
	localparam logic [1:0] SRC_LOW128 = 2'h1;
	localparam logic [1:0] SRC_EXT = 2'h2;
	localparam logic [1:0] SRC_RSVD = 2'h3;
	// values after reset
	localparam logic [1:0] SOURCE_RESET = 2'h0;
	localparam logic [3:0] DIVIDER_RESET = 4'h3;
	// unlock signature and length of the write window in instruction cycles
	localparam logic [7:0] UNLOCK_SIGNATURE = 8'hd8;
	localparam logic [2:0] PROTECT_CYCLES = 3'h4;
	// field positions
	localparam int SOURCE_FIELD_MSB = 1;
	localparam int DIVIDER_FIELD_MSB = 3;
	localparam int PROTECT_FLAG_POS = 0;

	typedef enum logic [1:0] {
		SLEEP_ACTIVE,
		SLEEP_IDLE,
		SLEEP_CONVERT,
		SLEEP_POWERDOWN
	} mcsd_sleep_t;
endpackage

//--- rtl/mcsd_div_if.sv
/*
 * mcsd_div_if: carries main clock ticks and divider select into the
 * system divider and the divided tick back out.
 * assumes: both ends run on mclk.
 */
`timescale 1ns/100ps
`default_nettype none
interface mcsd_div_if;
	logic mainTick;
	logic [3:0] divSel;
	logic sysTick;
	modport ctrl (output mainTick, output divSel, input sysTick);
	modport div (input mainTick, input divSel, output sysTick);
endinterface
`default_nettype wire

//--- rtl/mcsd_prescaler.sv
/*
 * mcsd_prescaler: power-of-two divider of the main clock tick stream.
 * assumes: mainTick is a one-cycle pulse on mclk; divSel from a register.
 */
`timescale 1ns/100ps
`default_nettype none
module mcsd_prescaler
	import mcsd_pkg::*;
#(
	parameter int MAX_CODE = 8
) (
	// clock and reset
	input wire logic mclk,
	input wire logic sys_rst,
	// divider link
	mcsd_div_if.div link
);
	if (MAX_CODE < 0 || MAX_CODE > 8) begin : g_check
		$error("mcsd_prescaler: MAX_CODE must be 0 to 8");
	end

	function automatic logic [7:0] limitOf(input logic [3:0] code);
		logic [3:0] c;
		c = (code > 4'(MAX_CODE)) ? 4'(MAX_CODE) : code;
		limitOf = 8'((9'h001 << c) - 9'h001);
	endfunction

	logic [7:0] count_reg, count_next;
	logic [7:0] limit_reg, limit_next;
	logic tick_reg, tick_next;

	// new limit taken only at a period boundary: no short period appears
	always_comb begin
		count_next = count_reg;
		limit_next = limit_reg;
		tick_next = 1'b0;
		if (link.mainTick) begin
			if (count_reg >= limit_reg) begin
				count_next = 8'h00;
				tick_next = 1'b1;
				limit_next = limitOf(link.divSel);
			end else begin
				count_next = count_reg + 8'h01;
			end
		end
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			count_reg <= 8'h00;
			limit_reg <= 8'h07;
			tick_reg <= 1'b0;
		end else begin
			count_reg <= count_next;
			limit_reg <= limit_next;
			tick_reg <= tick_next;
		end
	end

	assign link.sysTick = tick_reg;

	AST_TICK_ON_MAIN: assert property (@(posedge mclk) disable iff (sys_rst)
		tick_reg |-> $past(link.mainTick))
		else $error("system tick without main tick");
	AST_LIMIT_POW2: assert property (@(posedge mclk) disable iff (sys_rst)
		((limit_reg + 8'h01) & limit_reg) == 8'h00)
		else $error("divider limit not a power of two");
	AST_LIMIT_AT_BOUNDARY: assert property (@(posedge mclk) disable iff (sys_rst)
		!$stable(limit_reg) |-> tick_reg)
		else $error("divider limit changed inside a period");
endmodule // mcsd_prescaler
`default_nettype wire

//--- rtl/main_clock_select_and_distribution.sv
/*
 * main_clock_select_and_distribution: picks the main clock from three
 * sampled sources, divides it and hands out gated domain tick enables.
 * assumes: oscillator and external clock pins are far slower than mclk
 * and arrive asynchronous; the i/o write port is on mclk.
 */
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - select code picks 8M, 128k, external
// - all domain ticks except watchdog derive from main clock
// - source switch without glitch or runt pulse
// - reset selects calibrated 8 MHz oscillator
// - divider resets to divide by eight
// - divider rewrite reaches every synchronous domain
// - reset loads factory trim byte
// - watchdog ticks always from low oscillator
// - core domain halts with its enable
// - peripheral domain; interrupt pin seen ungated
// - nonvolatile domain follows core domain
// - converter domain runs in convert sleep
// - sleep mode gates unused domains
// - signature opens four-cycle protected write window
// - divider code gives power of two
// - new divisor starts at period boundary
module main_clock_select_and_distribution
	import mcsd_pkg::*;
(
	// clock and reset
	input wire logic mclk,
	input wire logic sys_rst,
	// clock source pins
	input wire logic int8Osc,
	input wire logic low128Osc,
	input wire logic external_clock_input,
	// external interrupt pin
	input wire logic extIntPin,
	// i/o write port from the core
	input wire logic ioWrite,
	input wire logic [5:0] ioAddr,
	input wire logic [7:0] ioWrData,
	// factory trim and sleep control
	input wire logic [7:0] factoryTrim,
	input wire logic [1:0] sleepMode,
	// register contents
	output logic [7:0] main_source_settings_reg,
	output logic [7:0] system_divider_reg,
	output logic [7:0] oscillator_trim_reg,
	output logic [7:0] change_protection_reg,
	output logic interruptBlock,
	// domain tick enables and synchronised interrupt pin level
	output logic mainTick,
	output logic core_clock,
	output logic peripheral_clock,
	output logic nonvolatile_ctrl_clock,
	output logic converter_clock,
	output logic watchdogTick,
	output logic extIntDetect
);
	typedef enum {SW_RUN, SW_WAIT_LOW, SW_WAIT_HIGH} mcsd_sw_t;

	// synchronisers: stage a feeds only stage b
	logic [3:0] syncA_reg, syncB_reg, syncC_reg;
	logic [3:0] pins;
	assign pins = {extIntPin, external_clock_input, low128Osc, int8Osc};
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			syncA_reg <= 4'h0;
			syncB_reg <= 4'h0;
			syncC_reg <= 4'h0;
		end else begin
			syncA_reg <= pins;
			syncB_reg <= syncA_reg;
			syncC_reg <= syncB_reg;
		end
	end

	function automatic logic srcLevel(input logic [1:0] code, input logic [3:0] v);
		case (code)
			SRC_INT8: srcLevel = v[0];
			SRC_LOW128: srcLevel = v[1];
			SRC_EXT: srcLevel = v[2];
			default: srcLevel = v[0];
		endcase
	endfunction

	function automatic logic srcRise(input logic [1:0] code);
		srcRise = srcLevel(code, syncB_reg) & ~srcLevel(code, syncC_reg);
	endfunction

	// register write decode
	logic wrProtect, wrSource, wrDivider, wrTrim, windowOpen;
	assign windowOpen = change_protection_reg[PROTECT_FLAG_POS];
	assign wrProtect = ioWrite && ioAddr == OFS_PROTECT;
	assign wrSource = ioWrite && ioAddr == OFS_SOURCE && windowOpen;
	assign wrDivider = ioWrite && ioAddr == OFS_DIVIDER && windowOpen;
	assign wrTrim = ioWrite && ioAddr == OFS_TRIM;

	// protection window, counted in core instruction cycles
	logic [2:0] window_reg, window_next;
	always_comb begin
		window_next = window_reg;
		if (wrProtect && ioWrData == UNLOCK_SIGNATURE) begin
			window_next = PROTECT_CYCLES;
		end else if (window_reg != 3'h0 && core_clock) begin
			window_next = window_reg - 3'h1;
		end
	end

	// configuration registers
	logic [1:0] reqSrc_reg, reqSrc_next;
	logic [3:0] divSel_reg, divSel_next;
	logic [7:0] trim_reg, trim_next;
	logic trimLoad_reg, trimLoad_next;
	always_comb begin
		reqSrc_next = reqSrc_reg;
		divSel_next = divSel_reg;
		trim_next = trim_reg;
		trimLoad_next = 1'b0;
		if (trimLoad_reg) begin
			trim_next = factoryTrim;
		end else if (wrTrim) begin
			trim_next = ioWrData;
		end
		if (wrSource && ioWrData[SOURCE_FIELD_MSB:0] != SRC_RSVD) begin
			reqSrc_next = ioWrData[SOURCE_FIELD_MSB:0];
		end
		if (wrDivider) begin
			divSel_next = ioWrData[DIVIDER_FIELD_MSB:0];
		end
	end

	// glitch-free switch: old source muted, new one used from its first rise after a low level is seen
	mcsd_sw_t sw_reg, sw_next;
	logic [1:0] actSrc_reg, actSrc_next;
	logic mainTickNext;
	always_comb begin
		sw_next = sw_reg;
		actSrc_next = actSrc_reg;
		mainTickNext = 1'b0;
		case (sw_reg)
			SW_RUN: begin
				if (reqSrc_reg != actSrc_reg) begin
					actSrc_next = reqSrc_reg;
					sw_next = SW_WAIT_LOW;
				end else begin
					mainTickNext = srcRise(actSrc_reg);
				end
			end
			SW_WAIT_LOW: begin
				if (!srcLevel(actSrc_reg, syncB_reg)) begin
					sw_next = SW_WAIT_HIGH;
				end
			end
			SW_WAIT_HIGH: begin
				if (srcRise(actSrc_reg)) begin
					mainTickNext = 1'b1;
					sw_next = SW_RUN;
				end
			end
			default: sw_next = SW_RUN;
		endcase
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			window_reg <= 3'h0;
			reqSrc_reg <= SOURCE_RESET;
			actSrc_reg <= SOURCE_RESET;
			divSel_reg <= DIVIDER_RESET;
			trim_reg <= 8'h00;
			trimLoad_reg <= 1'b1;
			sw_reg <= SW_RUN;
			mainTick <= 1'b0;
		end else begin
			window_reg <= window_next;
			reqSrc_reg <= reqSrc_next;
			actSrc_reg <= actSrc_next;
			divSel_reg <= divSel_next;
			trim_reg <= trim_next;
			trimLoad_reg <= trimLoad_next;
			sw_reg <= sw_next;
			mainTick <= mainTickNext;
		end
	end

	// system divider
	mcsd_div_if divLink();
	assign divLink.mainTick = mainTick;
	assign divLink.divSel = divSel_reg;
	mcsd_prescaler #(
		.MAX_CODE(8)
	) u_prescaler (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.link(divLink.div)
	);

	// domain gating by sleep mode
	// gate applied combinationally in front of the tick flop, so a tick is never cut short
	// limitation: window above still waits for core ticks, so power down freezes it
	logic coreOn, periphOn, convOn;
	always_comb begin
		coreOn = 1'b0;
		periphOn = 1'b0;
		convOn = 1'b0;
		case (sleepMode)
			SLEEP_ACTIVE: begin
				coreOn = 1'b1;
				periphOn = 1'b1;
				convOn = 1'b1;
			end
			SLEEP_IDLE: begin
				periphOn = 1'b1;
				convOn = 1'b1;
			end
			SLEEP_CONVERT: convOn = 1'b1;
			default: ; // power down: core, peripheral and converter domains stopped
		endcase
	end

	logic coreTick_reg, periphTick_reg, nvmTick_reg, convTick_reg, wdtTick_reg, extInt_reg;
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			coreTick_reg <= 1'b0;
			periphTick_reg <= 1'b0;
			nvmTick_reg <= 1'b0;
			convTick_reg <= 1'b0;
			wdtTick_reg <= 1'b0;
			extInt_reg <= 1'b0;
		end else begin
			coreTick_reg <= divLink.sysTick && coreOn;
			periphTick_reg <= divLink.sysTick && periphOn;
			nvmTick_reg <= divLink.sysTick && coreOn;
			convTick_reg <= divLink.sysTick && convOn;
			wdtTick_reg <= syncB_reg[1] & ~syncC_reg[1];
			extInt_reg <= syncB_reg[3]; // seen even with peripherals stopped
		end
	end

	assign core_clock = coreTick_reg;
	assign peripheral_clock = periphTick_reg;
	assign nonvolatile_ctrl_clock = nvmTick_reg;
	assign converter_clock = convTick_reg;
	assign watchdogTick = wdtTick_reg;
	assign extIntDetect = extInt_reg;
	assign main_source_settings_reg = {6'h00, reqSrc_reg};
	assign system_divider_reg = {4'h0, divSel_reg};
	assign oscillator_trim_reg = trim_reg;
	assign change_protection_reg = {7'h00, window_reg != 3'h0};
	assign interruptBlock = window_reg != 3'h0;

	AST_WRITE_LOCKED: assert property (@(posedge mclk) disable iff (sys_rst)
		(ioWrite && ioAddr == OFS_SOURCE && !windowOpen) |=> $stable(reqSrc_reg))
		else $error("source changed without unlock");
	AST_WINDOW_OPENS: assert property (@(posedge mclk) disable iff (sys_rst)
		(wrProtect && ioWrData == UNLOCK_SIGNATURE) |=> window_reg == 3'h4)
		else $error("window not opened to four cycles");
	AST_RSVD_IGNORED: assert property (@(posedge mclk) disable iff (sys_rst)
		(wrSource && ioWrData[1:0] == SRC_RSVD) |=> $stable(reqSrc_reg))
		else $error("reserved source code accepted");
	AST_NO_TICK_IN_SWITCH: assert property (@(posedge mclk) disable iff (sys_rst)
		(sw_reg == SW_RUN && sw_next == SW_WAIT_LOW) |=> !mainTick [*2])
		else $error("main tick during source switch");
	AST_RESET_SOURCE: assert property (@(posedge mclk)
		$fell(sys_rst) |-> actSrc_reg == SRC_INT8 && divSel_reg == 4'h3)
		else $error("reset source or divider wrong");
	AST_TRIM_LOADED: assert property (@(posedge mclk) disable iff (sys_rst)
		trimLoad_reg |=> trim_reg == $past(factoryTrim))
		else $error("factory trim not loaded");
	AST_NVM_WITH_CORE: assert property (@(posedge mclk) disable iff (sys_rst)
		nonvolatile_ctrl_clock == core_clock)
		else $error("nonvolatile domain differs from core domain");
	AST_POWERDOWN_GATED: assert property (@(posedge mclk) disable iff (sys_rst)
		($past(sleepMode) == 2'h3) |-> !core_clock && !peripheral_clock && !converter_clock)
		else $error("domain ticking in power down");
	AST_CONV_SLEEP: assert property (@(posedge mclk) disable iff (sys_rst)
		($past(sleepMode) == 2'h2 && $past(divLink.sysTick)) |-> converter_clock && !core_clock)
		else $error("converter domain gating wrong");

	// write paths checked against the written data; window end, core source, idle gating
	AST_SRC_WRITE: assert property (@(posedge mclk) disable iff (sys_rst)
		(wrSource && ioWrData[1:0] != SRC_RSVD) |=> reqSrc_reg == $past(ioWrData[1:0]))
		else $error("accepted source code not stored");
	AST_DIV_WRITE: assert property (@(posedge mclk) disable iff (sys_rst)
		wrDivider |=> divSel_reg == $past(ioWrData[3:0]))
		else $error("accepted divider code not stored");
	AST_WINDOW_CLOSES: assert property (@(posedge mclk) disable iff (sys_rst)
		(window_reg == 3'h1 && core_clock && !wrProtect) |=> !windowOpen)
		else $error("protected window outlived its four cycles");
	AST_CORE_FROM_SYS: assert property (@(posedge mclk) disable iff (sys_rst)
		core_clock |-> $past(divLink.sysTick))
		else $error("core tick without system tick");
	AST_IDLE_GATED: assert property (@(posedge mclk) disable iff (sys_rst)
		($past(sleepMode) == 2'h1 && $past(divLink.sysTick)) |-> peripheral_clock && !core_clock)
		else $error("idle domain gating wrong");
endmodule // main_clock_select_and_distribution
`default_nettype wire

//--- tb/mcsd_osc_model.sv
/*
 * mcsd_osc_model: the three main clock sources seen at the block's pins.
 * assumes: a bench that only observes the pins; periods are in ns.
 */
`timescale 1ns/100ps
`default_nettype none
module mcsd_osc_model #(
	parameter int INT_NS = 125,
	parameter int LOW_NS = 1000,
	parameter int EXT_NS = 200
) (
	// source pins
	output logic int8Osc,
	output logic low128Osc,
	output logic extClk
);
	initial begin
		int8Osc = 1'b0;
		low128Osc = 1'b0;
		extClk = 1'b0;
	end
	// the low source is sped up so a switch costs tens of cycles, not hundreds
	always #(INT_NS / 2.0) int8Osc = ~int8Osc;
	always #(LOW_NS / 2.0) low128Osc = ~low128Osc;
	// fixed period, so the external source never jumps in frequency
	always #(EXT_NS / 2.0) extClk = ~extClk;
endmodule // mcsd_osc_model
`default_nettype wire

//--- tb/main_clock_select_and_distribution_tb_top.sv
/*
 * main_clock_select_and_distribution_tb_top: self-checking bench.
 * assumes: mcsd_osc_model drives the source pins; mclk is 40 MHz.
 */
`timescale 1ns/100ps
`default_nettype none
module main_clock_select_and_distribution_tb_top;
	import mcsd_pkg::*;
	localparam int LIMIT = 60000;
	localparam int LOW_NS = 1000;
	localparam int EXT_NS = 200;
	localparam logic [7:0] TRIM = 8'h5a;
	logic mclk, sysRst, int8Osc, low128Osc, extClkIn, extIntPin, ioWrite;
	logic [5:0] ioAddr;
	logic [7:0] ioWrData, srcReg, divReg, trimReg, protReg;
	logic [1:0] sleepMode;
	logic intBlock, mainTick, coreClk, perClk, nvmClk, convClk, wdTick, extIntDetect;
	int numErrors, nCompared, cycles, gap, minGap;

	mcsd_osc_model #(.LOW_NS(LOW_NS), .EXT_NS(EXT_NS)) osc (.int8Osc(int8Osc),
		.low128Osc(low128Osc), .extClk(extClkIn));
	main_clock_select_and_distribution dut (.mclk(mclk), .sys_rst(sysRst),
		.int8Osc(int8Osc), .low128Osc(low128Osc), .external_clock_input(extClkIn),
		.extIntPin(extIntPin), .ioWrite(ioWrite), .ioAddr(ioAddr), .ioWrData(ioWrData),
		.factoryTrim(TRIM), .sleepMode(sleepMode), .main_source_settings_reg(srcReg),
		.system_divider_reg(divReg), .oscillator_trim_reg(trimReg),
		.change_protection_reg(protReg), .interruptBlock(intBlock), .mainTick(mainTick),
		.core_clock(coreClk), .peripheral_clock(perClk), .nonvolatile_ctrl_clock(nvmClk),
		.converter_clock(convClk), .watchdogTick(wdTick), .extIntDetect(extIntDetect));

	initial mclk = 1'b0;
	always #12.5 mclk = ~mclk;

	task automatic completeRun();
		if (numErrors == 0 && nCompared > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		nCompared++;
		if (seen !== exp) begin
			numErrors++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	always @(posedge mclk) begin
		cycles++;
		if (cycles == LIMIT) begin
			numErrors++;
			completeRun();
		end
	end
	// shortest gap between main ticks; a runt on a switch shows up here
	always @(posedge mclk) begin
		if (sysRst) gap = 100;
		else if (mainTick === 1'b1) begin
			if (gap < minGap) minGap = gap;
			gap = 0;
		end else gap++;
	end

	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask

	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		ioWrite = 1'b1;
		ioAddr = a;
		ioWrData = d;
		cyc(1);
		ioWrite = 1'b0;
		cyc(1);
	endtask

	// unlock then write at once, well inside the window
	task automatic prot(input logic [5:0] a, input logic [7:0] d);
		wr(OFS_PROTECT, UNLOCK_SIGNATURE);
		wr(a, d);
	endtask

	task automatic nextCore(output int ticks);
		ticks = 0;
		repeat (4000) begin
			cyc(1);
			if (mainTick === 1'b1) ticks++;
			if (coreClk === 1'b1) return;
		end
	endtask

	task automatic nextMain(output int n);
		n = 0;
		repeat (400) begin
			cyc(1);
			n++;
			if (mainTick === 1'b1) return;
		end
	endtask

	task automatic resetDut();
		sysRst = 1'b1;
		cyc(5);
		sysRst = 1'b0;
		cyc(2);
		check(srcReg, 8'h00);
		check(divReg, 8'h03);
		check(trimReg, TRIM);
		check(protReg, 8'h00);
	endtask

	task automatic testDivider();
		int t;
		wr(OFS_DIVIDER, 8'h00);
		check(divReg, 8'h03);
		nextCore(t);
		nextCore(t);
		check(8'(t), 8'h08);
		wr(OFS_PROTECT, UNLOCK_SIGNATURE);
		check({7'h0, intBlock}, 8'h01);
		check(protReg, 8'h01);
		for (int c = 0; c < 5; c++) begin
			prot(OFS_DIVIDER, 8'(c));
			check(divReg, 8'(c));
			repeat (3) nextCore(t);
			check(8'(t), 8'(1 << c));
		end
	endtask

	task automatic testSource();
		int n, e;
		for (int s = 1; s < 5; s++) begin
			prot(OFS_SOURCE, 8'(s % 4));
			e = (s == 1) ? LOW_NS / 25 : (s == 4) ? 5 : EXT_NS / 25;
			check(srcReg, (s == 3) ? 8'h02 : 8'(s % 4));
			repeat (3) nextMain(n);
			check({7'h0, n >= e - 1 && n <= e + 1}, 8'h01);
		end
		wr(OFS_TRIM, 8'h3c);
		check(trimReg, 8'h3c);
	endtask

	task automatic testSleep();
		logic [4:0] seen;
		logic [3:0] want [4] = '{4'hf, 4'h5, 4'h1, 4'h0};
		prot(OFS_DIVIDER, 8'h00);
		for (int m = 0; m < 4; m++) begin
			sleepMode = 2'(m);
			cyc(3);
			seen = 5'h00;
			repeat (100) begin
				cyc(1);
				seen |= {coreClk, perClk, nvmClk, convClk, wdTick};
			end
			check({3'h0, seen}, {3'h0, want[m], 1'b1});
		end
		extIntPin = 1'b1;
		cyc(4);
		check({7'h0, extIntDetect}, 8'h01);
		extIntPin = 1'b0;
		sleepMode = 2'h0;
	endtask

	initial begin
		sysRst = 1'b1;
		ioWrite = 1'b0;
		ioAddr = 6'h00;
		ioWrData = 8'h00;
		extIntPin = 1'b0;
		sleepMode = 2'h0;
		minGap = 1000;
		gap = 100;
		cycles = 0;
		numErrors = 0;
		nCompared = 0;
		resetDut();
		testDivider();
		testSource();
		testSleep();
		// reset from the low source must land back on the fast one
		prot(OFS_SOURCE, 8'h01);
		cyc(50);
		resetDut();
		check({7'h0, minGap >= 3}, 8'h01);
		completeRun();
	end
endmodule // main_clock_select_and_distribution_tb_top
`default_nettype wire
